// ---- hdl/sparm_matrix.sv ----
// Stereo pair audio routing matrix with input and output channel assignment.
`timescale 1ns/1ps
module sparm_matrix (
  input  wire logic                                   sys_clk,         // 10 MHz core clock.
  input  wire logic                                   sys_rst,         // Synchronous reset, active high.
  input  wire sparm_pkg::sparm_variant_type           variant,         // Converter population.
  input  wire logic                                   frame_strobe,    // One-cycle pulse at each sample frame.
  input  wire logic [8:0][4:0]                        in_port_count,   // Channels per input port mode.
  input  wire logic                                   in_valid,        // Input slot sample present.
  input  wire logic [3:0]                             in_port,         // Input port of the sample.
  input  wire logic [4:0]                             in_slot,         // Slot within that port frame.
  input  wire logic [23:0]                            serial_input_port_data, // Input slot sample.
  input  wire logic [1:0][23:0]                       rx_pair,         // Receiver left and right.
  input  wire logic [15:0][23:0]                      core_conv_data,  // Core-to-converter channels.
  input  wire logic [1:0][23:0]                       core_tx_pair,    // Core transmitter pair.
  input  wire logic [23:0][23:0]                      core_out_data,   // Core output channels.
  input  wire logic [15:0][23:0]                      conv_out_data,   // Converter output channels.
  input  wire logic [7:0][5:0]                        conv_in_sel,     // Converter input selector per pair.
  input  wire logic [11:0][4:0]                       ser_out_sel,     // Serial output selector per pair.
  input  wire logic [8:0][4:0]                        out_port_count,  // Channels per output port mode.
  input  wire logic                                   out_rd,          // Output port asks for a slot.
  input  wire logic [3:0]                             out_port,        // Output port asking.
  input  wire logic [4:0]                             out_slot,        // Slot within that port frame.
  output logic      [23:0][23:0]                      dsp_in_data,     // Input channels to the core.
  output logic      [1:0][23:0]                       dsp_rx_data,     // Receiver pair to the core.
  output logic      [15:0][23:0]                      dsp_conv_data,   // Converter outputs to the core.
  output logic      [15:0][23:0]                      conv_in_data,    // Converter input channels.
  output logic      [1:0][23:0]                       digital_audio_transmit_pin, // Transmitter pair.
  output logic      [23:0]                            serial_output_port_data, // Answer to a slot request.
  output logic                                        out_data_valid   // Answer present.
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [23:0][23:0] in_chan_q,  in_chan_d;
  logic [7:0][5:0]   in_sel_q,   in_sel_d;
  logic [11:0][4:0]  out_sel_q,  out_sel_d;
  logic [15:0][23:0] conv_in_q,  conv_in_d;
  logic [23:0][23:0] out_chan_q, out_chan_d;
  logic [1:0][23:0]  rx_q,       rx_d;
  logic [15:0][23:0] conv_out_q, conv_out_d;
  logic [1:0][23:0]  tx_q,       tx_d;
  logic [23:0]       odata_q,    odata_d;
  logic              ovalid_q,   ovalid_d;

  // ---------------------------------------------------------------
  // Input channel assignment
  // ---------------------------------------------------------------
  // Base of a port is the sum of earlier port counts, so an idle pin still takes its block.
  always_comb
  begin
    logic [7:0] base;
    logic [7:0] idx;
    base      = 8'h00;
    idx       = 8'h00;
    in_chan_d = in_chan_q;
    for (int p = 0; p < sparm_pkg::NUM_PORTS; p++)
    begin
      if (p < 32'(in_port))
      begin
        base = base + 8'(in_port_count[p]);
      end
    end
    idx = base + 8'(in_slot);
    if (in_valid && (in_port < 4'(sparm_pkg::NUM_PORTS)) && (in_slot < in_port_count[in_port])
        && (idx < 8'(sparm_pkg::NUM_CH)))
    begin
      in_chan_d[idx[4:0]] = serial_input_port_data;
    end
  end

  // ---------------------------------------------------------------
  // Selection staging
  // ---------------------------------------------------------------
  // Selections only move at a frame edge, so left and right of a pair never come from two sources.
  always_comb
  begin
    in_sel_d  = in_sel_q;
    out_sel_d = out_sel_q;
    if (frame_strobe)
    begin
      in_sel_d  = conv_in_sel;
      out_sel_d = ser_out_sel;
    end
  end

  // ---------------------------------------------------------------
  // Input side crossbar
  // ---------------------------------------------------------------
  // Destination pair d drives converter d in every populated variant; codes outside the map give silence.
  always_comb
  begin
    logic [5:0] code;
    logic [5:0] off;
    code      = 6'h00;
    off       = 6'h00;
    conv_in_d = '0;
    for (int d = 0; d < sparm_pkg::CONV_PAIRS; d++)
    begin
      code = in_sel_q[d];
      if (variant == sparm_pkg::SPARM_NO_CONV)
      begin
        conv_in_d[2*d]   = 24'h00_0000;
        conv_in_d[2*d+1] = 24'h00_0000;
      end
      else if (code < sparm_pkg::IN_SEL_SERIAL + 6'(sparm_pkg::NUM_PAIRS))
      begin
        off              = code - sparm_pkg::IN_SEL_SERIAL;
        conv_in_d[2*d]   = in_chan_q[{off[3:0], 1'b0}];
        conv_in_d[2*d+1] = in_chan_q[{off[3:0], 1'b1}];
      end
      else if ((code >= sparm_pkg::IN_SEL_CORE) && (code < sparm_pkg::IN_SEL_CORE + 6'(sparm_pkg::CONV_PAIRS)))
      begin
        off              = code - sparm_pkg::IN_SEL_CORE;
        conv_in_d[2*d]   = core_conv_data[{off[2:0], 1'b0}];
        conv_in_d[2*d+1] = core_conv_data[{off[2:0], 1'b1}];
      end
      else if (code == sparm_pkg::IN_SEL_RX)
      begin
        conv_in_d[2*d]   = rx_pair[0];
        conv_in_d[2*d+1] = rx_pair[1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Fixed paths to the core and the transmit pin
  // ---------------------------------------------------------------
  always_comb
  begin
    rx_d       = rx_pair;
    conv_out_d = conv_out_data;
    tx_d       = core_tx_pair;
  end

  // ---------------------------------------------------------------
  // Output side crossbar
  // ---------------------------------------------------------------
  // Core outputs have no fixed route here; they appear only when a selector names them.
  always_comb
  begin
    logic [4:0] code;
    logic [4:0] off;
    code       = 5'h00;
    off        = 5'h00;
    out_chan_d = '0;
    for (int o = 0; o < sparm_pkg::NUM_PAIRS; o++)
    begin
      code = out_sel_q[o];
      if (code < sparm_pkg::OUT_SEL_CORE)
      begin
        off               = code - sparm_pkg::OUT_SEL_CONV;
        out_chan_d[2*o]   = conv_out_data[{off[2:0], 1'b0}];
        out_chan_d[2*o+1] = conv_out_data[{off[2:0], 1'b1}];
      end
      else if (code <= sparm_pkg::OUT_SEL_LAST)
      begin
        off               = code - sparm_pkg::OUT_SEL_CORE;
        out_chan_d[2*o]   = core_out_data[{off[3:0], 1'b0}];
        out_chan_d[2*o+1] = core_out_data[{off[3:0], 1'b1}];
      end
    end
  end

  // ---------------------------------------------------------------
  // Output channel assignment
  // ---------------------------------------------------------------
  // Ports are packed back to back with no gaps; a silent channel is still answered with zero.
  always_comb
  begin
    logic [7:0] base;
    logic [7:0] idx;
    base     = 8'h00;
    idx      = 8'h00;
    odata_d  = 24'h00_0000;
    ovalid_d = 1'b0;
    for (int p = 0; p < sparm_pkg::NUM_PORTS; p++)
    begin
      if (p < 32'(out_port))
      begin
        base = base + 8'(out_port_count[p]);
      end
    end
    idx = base + 8'(out_slot);
    if (out_rd && (out_port < 4'(sparm_pkg::NUM_PORTS)) && (out_slot < out_port_count[out_port]))
    begin
      ovalid_d = 1'b1;
      if (idx < 8'(sparm_pkg::NUM_CH))
      begin
        odata_d = out_chan_q[idx[4:0]];
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      in_chan_q  <= '0;
      in_sel_q   <= {8{sparm_pkg::IN_SEL_NONE}};
      out_sel_q  <= {12{sparm_pkg::OUT_SEL_NONE}};
      conv_in_q  <= '0;
      out_chan_q <= '0;
      rx_q       <= '0;
      conv_out_q <= '0;
      tx_q       <= '0;
      odata_q    <= 24'h00_0000;
      ovalid_q   <= 1'b0;
    end
    else
    begin
      in_chan_q  <= in_chan_d;
      in_sel_q   <= in_sel_d;
      out_sel_q  <= out_sel_d;
      conv_in_q  <= conv_in_d;
      out_chan_q <= out_chan_d;
      rx_q       <= rx_d;
      conv_out_q <= conv_out_d;
      tx_q       <= tx_d;
      odata_q    <= odata_d;
      ovalid_q   <= ovalid_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a flop; the core sees input channels with no selection in between.
  assign dsp_in_data                = in_chan_q;
  assign dsp_rx_data                = rx_q;
  assign dsp_conv_data              = conv_out_q;
  assign conv_in_data               = conv_in_q;
  assign digital_audio_transmit_pin = tx_q;
  assign serial_output_port_data    = odata_q;
  assign out_data_valid             = ovalid_q;

endmodule

// ---- hdl/sparm_pkg.sv ----
// Constants and types shared by the stereo pair audio routing matrix.
// How it works
// - All 24 assigned input channels go straight to the core and are also offered in pairs to the input crossbar.
// - The input crossbar takes 21 source pairs: 12 serial input pairs, the receiver pair and 8 core-to-converter pairs.
// - The input crossbar drives 8 converter input pairs, each taking one selected source pair, or silence for an unmapped code.
// - In the eight-converter variant destination pair n (channels 2n, 2n+1) feeds stereo converter n.
// - In the variant without converters the input crossbar is unused and inputs only reach the core.
// - The core transmitter pair goes straight to the transmit pin; the receiver pair reaches the crossbar and the core.
// - Every converter output pair goes to the core and to the output crossbar with no configuration.
// - The output crossbar picks one of 20 source pairs for each of the 12 serial output pairs.
// - Core output pairs reach the output channels only through the output crossbar selection.
// - The 24 output channels are handed to the nine output ports in order, each taking its mode's channel count.
// - Output assignment is contiguous and an unrouted channel still takes its slot on its port.
// - Converter input codes are 6 bits: 0-11 serial pairs, 16-23 core pairs, 32 receiver, all-ones no data at reset.
// - Input channels are handed to the input ports in order, each taking its mode's count, connected or not.
package sparm_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int SAMPLE_W     = 24;
  localparam int NUM_CH       = 24;
  localparam int NUM_PAIRS    = 12;
  localparam int CONV_PAIRS   = 8;
  localparam int NUM_PORTS    = 9;
  localparam int PORT_IDX_W   = 4;
  localparam int SLOT_W       = 5;
  localparam int BASE_W       = 8;

  // ---------------------------------------------------------------
  // Converter input selector codes
  // ---------------------------------------------------------------
  localparam int         IN_SEL_W      = 6;
  localparam logic [5:0] IN_SEL_SERIAL = 6'h00;
  localparam logic [5:0] IN_SEL_CORE   = 6'h10;
  localparam logic [5:0] IN_SEL_RX     = 6'h20;
  localparam logic [5:0] IN_SEL_NONE   = 6'h3F;

  // ---------------------------------------------------------------
  // Serial output selector codes
  // ---------------------------------------------------------------
  localparam int         OUT_SEL_W     = 5;
  localparam logic [4:0] OUT_SEL_CONV  = 5'h00;
  localparam logic [4:0] OUT_SEL_CORE  = 5'h08;
  localparam logic [4:0] OUT_SEL_LAST  = 5'h13;
  localparam logic [4:0] OUT_SEL_NONE  = 5'h1F;

  // ---------------------------------------------------------------
  // Converter population variants
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SPARM_EIGHT_CONV = 2'h0,
    SPARM_TWO_GROUP  = 2'h1,
    SPARM_NO_CONV    = 2'h2
  } sparm_variant_type;

endpackage

// ---- test/sparm_props.sv ----
// Concurrent checks on the routing matrix ports.
`timescale 1ns/1ps
module sparm_props (
  input wire logic                         sys_clk,        // Core clock.
  input wire logic                         sys_rst,        // Synchronous reset.
  input wire sparm_pkg::sparm_variant_type variant,        // Converter population.
  input wire logic [8:0][4:0]              in_port_count,  // Input port counts.
  input wire logic                         in_valid,       // Input slot strobe.
  input wire logic [3:0]                   in_port,        // Input port.
  input wire logic [4:0]                   in_slot,        // Input slot.
  input wire logic [23:0]                  serial_input_port_data, // Input sample.
  input wire logic [1:0][23:0]             rx_pair,        // Receiver pair.
  input wire logic [1:0][23:0]             core_tx_pair,   // Transmitter pair.
  input wire logic [15:0][23:0]            conv_out_data,  // Converter outputs.
  input wire logic [8:0][4:0]              out_port_count, // Output port counts.
  input wire logic                         out_rd,         // Slot request.
  input wire logic [3:0]                   out_port,       // Output port.
  input wire logic [4:0]                   out_slot,       // Output slot.
  input wire logic [23:0][23:0]            dsp_in_data,    // Core inputs.
  input wire logic [1:0][23:0]             dsp_rx_data,    // Receiver to core.
  input wire logic [15:0][23:0]            dsp_conv_data,  // Converters to core.
  input wire logic [15:0][23:0]            conv_in_data,   // Converter inputs.
  input wire logic [1:0][23:0]             digital_audio_transmit_pin, // Transmit pin.
  input wire logic                         out_data_valid  // Answer present.
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // The fixed paths are gated by the past reset so that the first edge after release is not judged.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_good_rd;
    out_rd && out_port < 4'h9 && out_slot < out_port_count[out_port];
  endsequence
  sequence s_bad_rd;
    out_rd && out_port >= 4'h9;
  endsequence
  tx_bypass_a: assert property (!$past(sys_rst) |-> digital_audio_transmit_pin == $past(core_tx_pair)) else $error("tx pair mismatch");
  rx_core_a: assert property (!$past(sys_rst) |-> dsp_rx_data == $past(rx_pair)) else $error("rx pair mismatch");
  conv_core_a: assert property (!$past(sys_rst) |-> dsp_conv_data == $past(conv_out_data)) else $error("conv path mismatch");
  out_answer_a: assert property (s_good_rd |=> out_data_valid) else $error("slot request unanswered");
  out_refuse_a: assert property (s_bad_rd |=> !out_data_valid) else $error("bad port answered");
  out_spurious_a: assert property (!out_rd |=> !out_data_valid) else $error("answer without request");
  no_conv_zero_a: assert property ((variant == sparm_pkg::SPARM_NO_CONV) [*2] |-> conv_in_data == '0) else $error("converter input not zero");
  in_assign_a: assert property (in_valid && in_port == 4'h0 && in_slot < in_port_count[0] |-> ##2 dsp_in_data[$past(in_slot, 2)] == $past(serial_input_port_data, 2)) else $error("input channel wrong");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !out_data_valid && dsp_in_data == '0) else $error("outputs not cleared");
endmodule
bind sparm_matrix sparm_props u_sparm_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .variant(variant),
  .in_port_count(in_port_count), .in_valid(in_valid), .in_port(in_port), .in_slot(in_slot),
  .serial_input_port_data(serial_input_port_data), .rx_pair(rx_pair), .core_tx_pair(core_tx_pair),
  .conv_out_data(conv_out_data), .out_port_count(out_port_count), .out_rd(out_rd), .out_port(out_port),
  .out_slot(out_slot), .dsp_in_data(dsp_in_data), .dsp_rx_data(dsp_rx_data), .dsp_conv_data(dsp_conv_data),
  .conv_in_data(conv_in_data), .digital_audio_transmit_pin(digital_audio_transmit_pin),
  .out_data_valid(out_data_valid));

// ---- test/sparm_far_model.sv ----
// Model of the core and converters that feed the routing matrix.
`timescale 1ns/1ps
module sparm_far_model (
  output logic [1:0][23:0]  rx_pair,        // Receiver pair.
  output logic [15:0][23:0] core_conv_data, // Core to converters.
  output logic [1:0][23:0]  core_tx_pair,   // Core transmitter pair.
  output logic [23:0][23:0] core_out_data,  // Core outputs.
  output logic [15:0][23:0] conv_out_data   // Converter outputs.
);
  // Every channel carries its own source tag, so a misroute shows as a wrong value.
  // Every source is a fixed combinational value, so the model needs no clock.
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      core_out_data[i] = 24'h20_0000 + 24'(i);
      if (i < 16) core_conv_data[i] = 24'h10_0000 + 24'(i);
      if (i < 16) conv_out_data[i] = 24'h30_0000 + 24'(i);
      if (i < 2) rx_pair[i] = 24'h40_0000 + 24'(i);
      if (i < 2) core_tx_pair[i] = 24'h50_0000 + 24'(i);
    end
  end
endmodule

// ---- test/stereo_pair_audio_routing_matrix_tb_top.sv ----
// Self-checking bench for the routing matrix.
`timescale 1ns/1ps
module stereo_pair_audio_routing_matrix_tb_top;
  logic sys_clk = 1'b0, sys_rst = 1'b1, frame_strobe = 1'b0, in_valid = 1'b0, out_rd = 1'b0, out_data_valid;
  sparm_pkg::sparm_variant_type variant = sparm_pkg::SPARM_EIGHT_CONV;
  logic [8:0][4:0] in_port_count, out_port_count;
  logic [3:0] in_port = 4'h0, out_port = 4'h0;
  logic [4:0] in_slot = 5'h00, out_slot = 5'h00;
  logic [23:0] sdata = 24'h00_0000, serial_output_port_data;
  logic [7:0][5:0] conv_in_sel;
  logic [11:0][4:0] ser_out_sel;
  logic [1:0][23:0] rx_pair, core_tx_pair, dsp_rx_data, digital_audio_transmit_pin;
  logic [15:0][23:0] core_conv_data, conv_out_data, dsp_conv_data, conv_in_data;
  logic [23:0][23:0] core_out_data, dsp_in_data;
  int bad_count = 0, tests_run = 0;
  initial forever #50 sys_clk = ~sys_clk;
  sparm_far_model u_sparm_far_model (.rx_pair(rx_pair), .core_conv_data(core_conv_data),
    .core_tx_pair(core_tx_pair), .core_out_data(core_out_data), .conv_out_data(conv_out_data));
  sparm_matrix u_sparm_matrix (.sys_clk(sys_clk), .sys_rst(sys_rst), .variant(variant), .frame_strobe(frame_strobe),
    .in_port_count(in_port_count), .in_valid(in_valid), .in_port(in_port), .in_slot(in_slot),
    .serial_input_port_data(sdata), .rx_pair(rx_pair), .core_conv_data(core_conv_data),
    .core_tx_pair(core_tx_pair), .core_out_data(core_out_data), .conv_out_data(conv_out_data),
    .conv_in_sel(conv_in_sel), .ser_out_sel(ser_out_sel), .out_port_count(out_port_count), .out_rd(out_rd),
    .out_port(out_port), .out_slot(out_slot), .dsp_in_data(dsp_in_data), .dsp_rx_data(dsp_rx_data),
    .dsp_conv_data(dsp_conv_data), .conv_in_data(conv_in_data),
    .digital_audio_transmit_pin(digital_audio_transmit_pin),
    .serial_output_port_data(serial_output_port_data), .out_data_valid(out_data_valid));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Compare with case equality so an unknown output never passes.
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Each pulse is lowered at the edge that takes it, so no request is seen twice.
  task automatic put(input logic [3:0] p, input logic [4:0] s, input logic [23:0] d);
    @(posedge sys_clk);
    in_valid <= 1'b1; in_port <= p; in_slot <= s; sdata <= d;
    @(posedge sys_clk);
    in_valid <= 1'b0;
  endtask
  task automatic strobe();
    @(posedge sys_clk);
    frame_strobe <= 1'b1;
    @(posedge sys_clk);
    frame_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] p, input logic [4:0] s, input logic v, input logic [23:0] d);
    @(posedge sys_clk);
    out_rd <= 1'b1; out_port <= p; out_slot <= s;
    @(posedge sys_clk);
    out_rd <= 1'b0;
    #1;
    chk({23'h0, out_data_valid}, {23'h0, v});
    if (v) chk(serial_output_port_data, d);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Channel 0 is filled while every selector is still none, so the crossbar must stay silent.
  task automatic t_inputs();
    put(4'h0, 5'h00, 24'hA0_0000);
    put(4'h1, 5'h02, 24'hA0_0004);
    put(4'h1, 5'h03, 24'hA0_0005);
    put(4'h2, 5'h00, 24'hA0_000A);
    put(4'h9, 5'h00, 24'hBB_BBBB);
    wait_n(3);
    chk(dsp_in_data[0], 24'hA0_0000);
    chk(conv_in_data[0], 24'h00_0000);
    chk(dsp_in_data[4], 24'hA0_0004);
    chk(dsp_in_data[5], 24'hA0_0005);
    chk(dsp_in_data[10], 24'hA0_000A);
    $display("inputs done");
  endtask
  // Selections set without a strobe must not reach the crossbar.
  task automatic t_in_xbar();
    @(posedge sys_clk);
    conv_in_sel[0] <= 6'h02; conv_in_sel[1] <= 6'h13; conv_in_sel[2] <= 6'h20; conv_in_sel[4] <= 6'h0C;
    wait_n(4); chk(conv_in_data[0], 24'h00_0000);
    strobe(); wait_n(4);
    chk(conv_in_data[0], 24'hA0_0004); chk(conv_in_data[1], 24'hA0_0005);
    chk(conv_in_data[2], 24'h10_0006); chk(conv_in_data[3], 24'h10_0007);
    chk(conv_in_data[4], 24'h40_0000); chk(conv_in_data[5], 24'h40_0001);
    chk(conv_in_data[6], 24'h00_0000); chk(conv_in_data[9], 24'h00_0000);
    $display("input crossbar done");
  endtask
  task automatic t_out();
    @(posedge sys_clk);
    ser_out_sel[0] <= 5'h01; ser_out_sel[4] <= 5'h0D;
    strobe(); wait_n(4);
    rd(4'h0, 5'h01, 1'b1, 24'h30_0003);
    rd(4'h1, 5'h01, 1'b1, 24'h20_000B);
    rd(4'h2, 5'h00, 1'b1, 24'h00_0000);
    rd(4'h2, 5'h04, 1'b0, 24'h00_0000);
    rd(4'h9, 5'h00, 1'b0, 24'h00_0000);
    chk(digital_audio_transmit_pin[1], 24'h50_0001);
    chk(dsp_rx_data[0], 24'h40_0000);
    chk(dsp_conv_data[5], 24'h30_0005);
    $display("output side done");
  endtask
  // A reset in mid-run must put every selector back to no data until the next frame strobe.
  task automatic t_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_n(2);
    chk(conv_in_data[2], 24'h00_0000);
    chk(dsp_in_data[4], 24'h00_0000);
    chk({23'h0, out_data_valid}, 24'h00_0000);
    strobe();
    wait_n(4);
    chk(conv_in_data[2], 24'h10_0006);
    $display("mid-run reset done");
  endtask
  // The two-group variant still routes every pair; only the no-converter variant silences the inputs.
  task automatic t_no_conv();
    @(posedge sys_clk);
    variant <= sparm_pkg::SPARM_TWO_GROUP;
    wait_n(4);
    chk(conv_in_data[3], 24'h10_0007);
    @(posedge sys_clk);
    variant <= sparm_pkg::SPARM_NO_CONV;
    wait_n(4);
    for (int i = 0; i < 16; i++) chk(conv_in_data[i], 24'h00_0000);
    $display("no converter done");
  endtask
  // Port counts give input channel bases 0, 2, 10 and output channel bases 0, 8, 10.
  initial
  begin
    for (int i = 0; i < 9; i++) in_port_count[i] = 5'h02;
    in_port_count[1] = 5'h08;
    in_port_count[2] = 5'h04;
    out_port_count = in_port_count;
    out_port_count[0] = 5'h08; out_port_count[1] = 5'h02;
    for (int i = 0; i < 8; i++) conv_in_sel[i] = 6'h3F;
    for (int i = 0; i < 12; i++) ser_out_sel[i] = 5'h1F;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_n(1);
    chk({23'h0, out_data_valid}, 24'h00_0000); chk(conv_in_data[0], 24'h00_0000);
    t_inputs();
    t_in_xbar();
    t_out();
    t_reset();
    t_no_conv();
    close_out();
  end
  // A hang past 2000 cycles, over twenty times the expected run of about 83 cycles, is cut short.
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule
